// file: shared/sem_host_defs.svh
// timing and layout constants for the semaphore host controller
// assumes a 250 MHz system clock
`ifndef SEM_HOST_DEFS_SVH
`define SEM_HOST_DEFS_SVH

// clock period in ns
`define SEM_CLK_NS 4
// least address and rw setup before the select falls, ns
`define SEM_SETUP_NS 10
// least select low time covering the read access, ns
`define SEM_ACCESS_NS 55
// least select high time between two accesses, ns
`define SEM_RECOVER_NS 20
// least times round up to whole cycles
`define SEM_SETUP_CYC ((`SEM_SETUP_NS + `SEM_CLK_NS - 1) / `SEM_CLK_NS)
`define SEM_ACCESS_CYC ((`SEM_ACCESS_NS + `SEM_CLK_NS - 1) / `SEM_CLK_NS)
`define SEM_RECOVER_CYC ((`SEM_RECOVER_NS + `SEM_CLK_NS - 1) / `SEM_CLK_NS)
// flops in the data input synchroniser
`define SEM_SYNC_STAGES 2
// number of flags and width of their index
`define SEM_FLAG_COUNT 8
`define SEM_INDEX_W 3
`define SEM_DATA_W 8
// reads of a contested flag before the request is withdrawn
`define SEM_MAX_POLLS 4
// flag values: low means owned by this side
`define SEM_FLAG_TAKE 1'h0
`define SEM_FLAG_FREE 1'h1

`endif

// file: shared/sem_host_pkg.sv
// types shared by the semaphore host controller
// assumes sem_host_defs.svh for the widths
`include "sem_host_defs.svh"

package sem_host_pkg;

  typedef enum logic [1:0] {
    OP_INIT = 2'h0,
    OP_ACQUIRE = 2'h1,
    OP_RELEASE = 2'h2,
    OP_READ = 2'h3
  } sem_op_t;

  typedef struct packed {
    sem_op_t op;
    logic [`SEM_INDEX_W-1:0] index;
  } sem_cmd_t;

  typedef struct packed {
    logic granted;
    logic flag;
  } sem_result_t;

endpackage

// file: verification/dual_port_semaphore_flags_tb.sv
// self-checking bench for the semaphore host controller
// assumes the flag device model drives the far side
`include "sem_host_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dual_port_semaphore_flags_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  sem_host_pkg::sem_cmd_t cmd = '0;
  logic cmd_ready, done, sel_n, oe_n, rw_n, data_oe_n;
  sem_host_pkg::sem_result_t result;
  logic [11:0] addr;
  logic [7:0] data_out, dev_q, bus;
  int error_cnt = 0;
  int n_compared = 0;
  always #2 sys_clk = ~sys_clk;
  assign bus = !data_oe_n ? data_out : dev_q;
  sem_host_ctrl #(.ADDR_W(12), .SETUP_CYC(1), .ACCESS_CYC(1),
    .RECOVER_CYC(1)) i_dut (.sys_clk(sys_clk),
    .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .done(done), .result(result),
    .semaphore_select_n(sel_n), .oe_n(oe_n), .rw_n(rw_n), .addr(addr),
    .data_out(data_out), .data_oe_n(data_oe_n), .data_in(bus));
  sem_flag_device #(.ADDR_W(12)) i_dev (.semaphore_select_n(sel_n),
    .oe_n(oe_n), .rw_n(rw_n), .addr(addr), .bus(bus), .dev_q(dev_q));
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input sem_host_pkg::sem_op_t op, input int i);
    int n;
    cmd.op = op;
    cmd.index = 3'(i);
    cmd_valid = 1'b1;
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 200) begin
      error_cnt++;
      give_verdict();
    end
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    for (n = 0; n < 200 && done !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 200) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task automatic sc_init();
    run(sem_host_pkg::OP_INIT, 0);
    for (int i = 0; i < 8; i++) begin
      check("left request", i_dev.req_l[i], 1'b1);
      check("right owner", i_dev.own_r[i], 1'b1);
      i_dev.right_wr(3'(i), 1'b1);
    end
  endtask
  task automatic sc_sweep();
    for (int i = 0; i < 8; i++) begin
      run(sem_host_pkg::OP_ACQUIRE, i);
      check("grant", result, 8'h02);
      check("right flag", !i_dev.own_r[i], 1'b1);
      i_dev.right_wr(3'(i), 1'b0);
      i_dev.right_wr(3'(i), 1'b1);
      run(sem_host_pkg::OP_READ, i);
      check("read", result.flag, 1'b0);
      run(sem_host_pkg::OP_RELEASE, i);
      check("freed", {i_dev.own_l[i], i_dev.own_r[i]}, 8'h00);
    end
  endtask
  task automatic sc_contest();
    int reads;
    i_dev.right_wr(3'h2, 1'b0);
    reads = i_dev.n_reads;
    run(sem_host_pkg::OP_ACQUIRE, 2);
    check("lost", result, 8'h01);
    check("polls", 8'(i_dev.n_reads - reads), 8'(`SEM_MAX_POLLS));
    check("withdrawn", i_dev.req_l[2], 1'b1);
    check("right keeps", i_dev.own_r[2], 1'b1);
    i_dev.right_wr(3'h2, 1'b1);
  endtask
  task automatic sc_handover();
    run(sem_host_pkg::OP_ACQUIRE, 3);
    i_dev.right_wr(3'h3, 1'b0);
    check("pending", i_dev.own_r[3], 1'b0);
    run(sem_host_pkg::OP_RELEASE, 3);
    check("handed", i_dev.own_r[3], 1'b1);
    run(sem_host_pkg::OP_RELEASE, 3);
    run(sem_host_pkg::OP_READ, 3);
    check("stray one", result.flag, 1'b1);
    check("new owner", i_dev.own_r[3], 1'b1);
    i_dev.right_wr(3'h3, 1'b1);
    check("free", i_dev.own_r[3], 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    check("select in reset", sel_n, 1'b1);
    reset_n = 1'b1;
    @(posedge sys_clk);
    #1;
    sc_init();
    sc_sweep();
    sc_contest();
    sc_handover();
    give_verdict();
  end
endmodule
`default_nettype wire

// file: verification/sem_flag_device.sv
// behavioural model of the eight flag semaphore device, both ports
// assumes left pins from the controller, right side by task calls
`timescale 1ns/1ps
`default_nettype none

module sem_flag_device #(
  parameter int ADDR_W = 12
) (
  // left side pins
  input wire logic semaphore_select_n,
  input wire logic oe_n,
  input wire logic rw_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] bus,
  output logic [7:0] dev_q
);
  // eight flags, no effect on any other resource
  logic [7:0] req_l = 8'h00;
  logic [7:0] req_r = 8'h00;
  logic [7:0] own_l = 8'hff;
  logic [7:0] own_r = 8'h00;
  logic rd_on = 1'b0;
  int n_reads = 0;
  initial dev_q = 8'h5a;
  // one write at a time, never ambiguous
  task automatic wr(input logic rt, input logic [2:0] i, input logic b);
    if (rt) begin
      req_r[i] = b;
    end else begin
      req_l[i] = b;
    end
    if (own_l[i] && req_l[i]) begin
      own_l[i] = 1'b0;
      own_r[i] = !req_r[i];
    end else if (own_r[i] && req_r[i]) begin
      own_r[i] = 1'b0;
      own_l[i] = !req_l[i];
    end else if (!own_l[i] && !own_r[i] && !b) begin
      own_l[i] = !rt;
      own_r[i] = rt;
    end
    // other cases keep ownership
  endtask
  task automatic right_wr(input logic [2:0] i, input logic b);
    wr(1'b1, i, b);
  endtask
  always @(posedge semaphore_select_n) begin
    if (rw_n === 1'b0) begin
      wr(1'b0, addr[2:0], bus[0]);
    end
  end
  always @(semaphore_select_n or oe_n) begin
    if (!semaphore_select_n && !oe_n && !rd_on) begin
      rd_on = 1'b1;
      n_reads++;
      dev_q = {8{!own_l[addr[2:0]]}};
    end else if ((semaphore_select_n || oe_n) && rd_on) begin
      rd_on = 1'b0;
      dev_q = ~dev_q;
    end
  end
endmodule
`default_nettype wire

// file: verification/sem_host_ctrl_asserts.sv
// pin checks for the semaphore host controller
// assumes it is bound into sem_host_ctrl
`include "sem_host_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sem_host_ctrl_asserts #(
  parameter int ADDR_W = 12,
  parameter int SETUP_CYC = `SEM_SETUP_CYC,
  parameter int ACCESS_CYC = `SEM_ACCESS_CYC,
  parameter int RECOVER_CYC = `SEM_RECOVER_CYC,
  parameter int MAX_POLLS = `SEM_MAX_POLLS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // command port
  input wire logic cmd_valid,
  input wire sem_host_pkg::sem_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic done,
  input wire sem_host_pkg::sem_result_t result,
  // device pins
  input wire logic semaphore_select_n,
  input wire logic oe_n,
  input wire logic rw_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [`SEM_DATA_W-1:0] data_out,
  input wire logic data_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  int hi_cnt;
  logic acq_reg;
  logic wbit_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt <= RECOVER_CYC;
    end else if (semaphore_select_n) begin
      hi_cnt <= hi_cnt + 1;
    end else begin
      hi_cnt <= 0;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acq_reg <= 1'b0;
    end else if (cmd_valid && cmd_ready) begin
      acq_reg <= cmd.op == sem_host_pkg::OP_ACQUIRE;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wbit_reg <= 1'b1;
    end else if (!semaphore_select_n && !rw_n) begin
      wbit_reg <= data_out[0];
    end
  end
  a_upper_addr_zero: assert property (addr[ADDR_W-1:3] == '0)
    else $error("address bits above the index not zero");
  a_oe_read_only: assert property (!oe_n |-> !semaphore_select_n && rw_n)
    else $error("output enable outside a read");
  a_write_replicated: assert property (!data_oe_n |-> !rw_n &&
    (data_out == 8'h00 || data_out == 8'hff))
    else $error("write data not replicated");
  a_pins_steady: assert property (!semaphore_select_n &&
    $past(!semaphore_select_n) |-> $stable(rw_n) && $stable(addr))
    else $error("rw or address moved under select");
  a_select_gap: assert property ($fell(semaphore_select_n) |->
    hi_cnt >= RECOVER_CYC)
    else $error("select high gap too short");
  a_done_pulse: assert property (done |-> cmd_ready ##1 !done)
    else $error("done not a single pulse");
  a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready [*2])
    else $error("ready stayed high after a take");
  a_acquire_writes: assert property (cmd_valid && cmd_ready &&
    cmd.op == sem_host_pkg::OP_ACQUIRE |-> ##[1:40]
    ($fell(semaphore_select_n) && !rw_n && data_out[0] == 1'b0))
    else $error("acquire did not start with a zero write");
  a_acquire_verdict: assert property (done && acq_reg |->
    result.granted == !result.flag)
    else $error("grant does not match the flag read");
  a_failed_withdraw: assert property (done && acq_reg &&
    !result.granted |-> wbit_reg)
    else $error("failed acquire left its request");
  c_won: cover property (done && acq_reg && result.granted);
  c_lost: cover property (done && acq_reg && !result.granted);
  c_write: cover property ($rose(semaphore_select_n) && !rw_n);
endmodule

bind sem_host_ctrl sem_host_ctrl_asserts #(.ADDR_W(ADDR_W),
  .SETUP_CYC(SETUP_CYC), .ACCESS_CYC(ACCESS_CYC),
  .RECOVER_CYC(RECOVER_CYC), .MAX_POLLS(MAX_POLLS)) i_asserts (
  .sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
  .cmd(cmd), .cmd_ready(cmd_ready), .done(done), .result(result),
  .semaphore_select_n(semaphore_select_n), .oe_n(oe_n), .rw_n(rw_n),
  .addr(addr), .data_out(data_out), .data_oe_n(data_oe_n));
`default_nettype wire

// file: verilog/sem_host_ctrl.sv
// one side's controller for the eight semaphore flags of a dual-port ram
// assumes the device pins are asynchronous; data pins are synchronised
// How it works
// RULE1: device holds eight independent flags
// RULE2: access by select low, oe and rw
// RULE3: flag index on three low address bits
// RULE4: only data bit zero is written
// RULE5: zero into free flag grants writer
// RULE6: owned flag ignores other side writes
// RULE7: owner writing one frees the flag
// RULE8: losing zero waits in request latch
// RULE9: release hands token to waiting side
// RULE10: new owner keeps flag until writing one
// RULE11: first zero request wins the token
// RULE12: pending request reads back one
// RULE13: read replicates flag on all bits
// RULE14: read value latched while select and oe
// RULE15: drop select and oe between reads
// RULE16: acquire by write zero then read
// RULE17: failed request: keep reading or withdraw
// RULE18: simultaneous semaphore accesses never ambiguous
// RULE19: flags block no resource
// RULE20: simultaneous equal requests grant one side
// RULE21: write one to every flag at start
// RULE22: stray one leaves flag unchanged
`include "sem_host_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sem_host_ctrl #(
  parameter int ADDR_W = 12,
  parameter int SETUP_CYC = `SEM_SETUP_CYC,
  parameter int ACCESS_CYC = `SEM_ACCESS_CYC,
  parameter int RECOVER_CYC = `SEM_RECOVER_CYC,
  parameter int MAX_POLLS = `SEM_MAX_POLLS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // command port
  input wire logic cmd_valid,
  input wire sem_host_pkg::sem_cmd_t cmd,
  output logic cmd_ready,
  output logic done,
  output sem_host_pkg::sem_result_t result,
  // device pins
  output logic semaphore_select_n,
  output logic oe_n,
  output logic rw_n,
  output logic [ADDR_W-1:0] addr,
  output logic [`SEM_DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [`SEM_DATA_W-1:0] data_in
);

  localparam int STROBE_CYC = ACCESS_CYC + `SEM_SYNC_STAGES + 1;

  generate
    if (ADDR_W < `SEM_INDEX_W || SETUP_CYC < 1 || ACCESS_CYC < 1 ||
        RECOVER_CYC < 1 || MAX_POLLS < 1 || STROBE_CYC > 255 ||
        SETUP_CYC > 255 || RECOVER_CYC > 255 || MAX_POLLS > 255)
    begin : g_bad
      $error("sem_host_ctrl parameters out of range");
    end
  endgenerate

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_RECOVER = 5'b01000,
    ST_FINISH = 5'b10000
  } state_t;

  // reading a flag: all bits carry the same value, bit zero is used
  function automatic logic flag_of(input logic [`SEM_DATA_W-1:0] d);
    flag_of = d[0]; // RULE13
  endfunction

  state_t state_reg;
  sem_host_pkg::sem_op_t op_reg;
  logic [`SEM_INDEX_W-1:0] index_reg;
  logic write_reg;
  logic wval_reg;
  logic withdraw_reg;
  logic [7:0] timer_reg;
  logic [7:0] polls_reg;
  logic flag_reg;
  logic granted_reg;
  logic done_reg;
  logic ready_reg;
  logic sel_n_reg;
  logic oe_n_reg;
  logic rw_n_reg;
  logic data_oe_n_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [`SEM_DATA_W-1:0] dout_reg;
  logic [`SEM_DATA_W-1:0] din_sync;
  logic timer_zero;
  logic sample_flag;

  sem_in_sync #(
    .WIDTH(`SEM_DATA_W),
    .STAGES(`SEM_SYNC_STAGES)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(data_in),
    .sync_out(din_sync)
  );

  assign timer_zero = (timer_reg == 8'h00);
  assign sample_flag = flag_of(din_sync);

  // sequencer: one access is setup, strobe, recover
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      op_reg <= sem_host_pkg::OP_READ;
      index_reg <= '0;
      write_reg <= 1'b0;
      wval_reg <= `SEM_FLAG_FREE;
      withdraw_reg <= 1'b0;
      timer_reg <= 8'h00;
      polls_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cmd_valid && ready_reg) begin
            op_reg <= cmd.op;
            withdraw_reg <= 1'b0;
            polls_reg <= 8'h00;
            timer_reg <= 8'(SETUP_CYC - 1);
            state_reg <= ST_SETUP;
            case (cmd.op)
              sem_host_pkg::OP_INIT: begin
                index_reg <= '0; // RULE21
                write_reg <= 1'b1;
                wval_reg <= `SEM_FLAG_FREE;
              end
              sem_host_pkg::OP_ACQUIRE: begin
                index_reg <= cmd.index;
                write_reg <= 1'b1; // RULE16
                wval_reg <= `SEM_FLAG_TAKE;
              end
              sem_host_pkg::OP_RELEASE: begin
                index_reg <= cmd.index;
                write_reg <= 1'b1;
                wval_reg <= `SEM_FLAG_FREE;
              end
              default: begin
                index_reg <= cmd.index;
                write_reg <= 1'b0;
                wval_reg <= `SEM_FLAG_FREE;
              end
            endcase
          end
        end
        ST_SETUP: begin
          if (timer_zero) begin
            timer_reg <= 8'(STROBE_CYC - 1);
            state_reg <= ST_STROBE;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        ST_STROBE: begin
          if (timer_zero) begin
            timer_reg <= 8'(RECOVER_CYC - 1); // RULE15
            state_reg <= ST_RECOVER;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        ST_RECOVER: begin
          if (!timer_zero) begin
            timer_reg <= timer_reg - 8'h01;
          end else begin
            timer_reg <= 8'(SETUP_CYC - 1);
            state_reg <= ST_FINISH;
            case (op_reg)
              sem_host_pkg::OP_INIT: begin
                if (index_reg != `SEM_INDEX_W'(`SEM_FLAG_COUNT - 1)) begin
                  index_reg <= index_reg + `SEM_INDEX_W'(1); // RULE21
                  state_reg <= ST_SETUP;
                end
              end
              sem_host_pkg::OP_ACQUIRE: begin
                if (write_reg && !withdraw_reg) begin
                  write_reg <= 1'b0; // RULE16
                  state_reg <= ST_SETUP;
                end else if (!write_reg && flag_reg != `SEM_FLAG_TAKE) begin
                  state_reg <= ST_SETUP;
                  if (polls_reg == 8'(MAX_POLLS - 1)) begin
                    write_reg <= 1'b1; // RULE17
                    wval_reg <= `SEM_FLAG_FREE;
                    withdraw_reg <= 1'b1;
                  end else begin
                    polls_reg <= polls_reg + 8'h01; // RULE17
                  end
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_FINISH: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // device pins, one cycle behind the sequencer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      rw_n_reg <= 1'b1;
      data_oe_n_reg <= 1'b1;
      addr_reg <= '0;
      dout_reg <= '0;
    end else begin
      sel_n_reg <= (state_reg != ST_STROBE); // RULE2
      oe_n_reg <= !(state_reg == ST_STROBE && !write_reg); // RULE15
      rw_n_reg <= !(write_reg && (state_reg == ST_SETUP ||
        state_reg == ST_STROBE || state_reg == ST_RECOVER));
      data_oe_n_reg <= !(write_reg && (state_reg == ST_SETUP ||
        state_reg == ST_STROBE || state_reg == ST_RECOVER));
      addr_reg <= ADDR_W'(index_reg); // RULE3
      dout_reg <= {`SEM_DATA_W{wval_reg}}; // RULE4
    end
  end

  // results and handshake
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= `SEM_FLAG_FREE;
      granted_reg <= 1'b0;
      done_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      if (state_reg == ST_STROBE && timer_zero && !write_reg) begin
        flag_reg <= sample_flag; // RULE14
      end
      if (state_reg == ST_IDLE && cmd_valid && ready_reg) begin
        ready_reg <= 1'b0;
        granted_reg <= 1'b0;
      end else if (state_reg == ST_FINISH) begin
        ready_reg <= 1'b1;
      end
      if (state_reg == ST_RECOVER && timer_zero && !write_reg &&
          op_reg == sem_host_pkg::OP_ACQUIRE) begin
        granted_reg <= (flag_reg == `SEM_FLAG_TAKE); // RULE16
      end
      done_reg <= (state_reg == ST_FINISH);
    end
  end

  assign cmd_ready = ready_reg;
  assign done = done_reg;
  assign result = '{granted: granted_reg, flag: flag_reg};
  assign semaphore_select_n = sel_n_reg;
  assign oe_n = oe_n_reg;
  assign rw_n = rw_n_reg;
  assign addr = addr_reg;
  assign data_out = dout_reg;
  assign data_oe_n = data_oe_n_reg;

endmodule

`default_nettype wire

// file: verilog/sem_in_sync.sv
// multi-bit two-flop synchroniser for the flag data pins
// assumes the pins change only while no sample is taken from them
`timescale 1ns/1ps
`default_nettype none

module sem_in_sync #(
  parameter int WIDTH = 8,
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // asynchronous input and its synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_reg [STAGES];

  generate
    if (STAGES < 2) begin : g_bad
      $error("sem_in_sync needs at least two stages");
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign sync_out = stage_reg[STAGES-1];

endmodule

`default_nettype wire
